// *** design/supply_supervisor_sleep_control.v ***
// supply supervisor and monitor control with sleep sequencing
// assumes an AXI4-Lite master on clock and asynchronous analog trip pins
//
// Function
// (R1) low supervisor state follows enable, keep, full bits
// (R2) automatic low side drops to normal or off in deep sleep
// (R3) low monitor keeps its state under manual control
// (R4) fast wake unless low side normal
// (R5) slow wake holds resumption about 150 us
// (R6) high side uses the same state mapping, save the automatic monitor in deep sleep (R13)
// (R7) deep entry waits for both settle flags
// (R8) wake request near entry is never lost
// (R9) reset returns sleep logic to normal
// (R10) software computes the affected configuration check
// (R11) software adds 150 us delay when needed
// (R12) overvoltage enable turns monitor event into reset
// (R13) automatic high monitor inactive in deep sleep
// (R14) low side event selects reset or interrupt
// (R15) low side normal mode means slow wake
// (R16) control write sets settle flag until settled
// (R17) unit states change with the power mode
`timescale 1ns/10ps
`include "supervisor_regs.vh"
module supply_supervisor_sleep_control #(
    parameter SLOW_US = `T_SLOW_US,
    parameter SLOW_CYCLES = `T_SLOW_US * `CLOCK_MHZ
) (
    input wire clock,
    input wire reset_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire wake_request,
    input wire low_sup_trip,
    input wire low_mon_trip,
    input wire high_sup_trip,
    input wire high_mon_trip,
    output reg [1:0] low_sup_state,
    output reg [1:0] low_mon_state,
    output reg [1:0] high_sup_state,
    output reg [1:0] high_mon_state,
    output reg cpu_hold,
    output reg power_on_reset,
    output reg irq
);

localparam ST_ACTIVE = 2'd0;
localparam ST_SLEEP = 2'd1;
localparam ST_WAKE = 2'd2;
localparam FAST_CYCLES = `T_FAST_US * `CLOCK_MHZ;
localparam [15:0] SLOW_LOAD = SLOW_CYCLES[15:0];
localparam [15:0] FAST_LOAD = FAST_CYCLES[15:0];
localparam [15:0] ONE_LOAD = 16'h0001;

// ----------------------------------------
// state mapping
// ----------------------------------------
function [1:0] sup_map;
    input en;
    input keep;
    input full;
    input auto;
    input deep;
    begin
        if (!en) begin
            sup_map = `UNIT_OFF;
        end else if (!deep || (!auto && keep)) begin
            sup_map = full ? `UNIT_FULL : `UNIT_NORMAL;
        end else if (auto && keep && full) begin
            sup_map = `UNIT_NORMAL;
        end else begin
            sup_map = `UNIT_OFF;
        end
    end
endfunction

function [1:0] mon_map;
    input en;
    input full;
    input auto;
    input deep;
    input auto_off;
    begin
        if (!en) begin
            mon_map = `UNIT_OFF;
        end else if (!deep || !auto) begin
            mon_map = full ? `UNIT_FULL : `UNIT_NORMAL;
        end else if (full && !auto_off) begin
            mon_map = `UNIT_NORMAL;
        end else begin
            mon_map = `UNIT_OFF;
        end
    end
endfunction

// ----------------------------------------
// storage
// ----------------------------------------
reg [`CTRL_WIDTH-1:0] low_side_control_reg;
reg [`CTRL_WIDTH-1:0] high_side_control_reg;
reg [4:0] event_flags;
reg [4:0] event_mask;
reg [1:0] state;
reg [2:0] power_level;
reg entry_pending;
reg [2:0] entry_level;
reg wake_latch;
reg [4:0] pin_meta;
reg [4:0] pin_sync;
reg [4:0] pin_last;
reg aw_held;
reg w_held;
reg [7:0] aw_addr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg [1:0] next_state;
reg [2:0] next_level;
reg wake_start;
reg entry_take;
wire low_settle_flag;
wire high_settle_flag;
wire wake_busy;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
always @(posedge clock) begin
    if (!reset_n) begin
        pin_meta <= 5'h00;
        pin_sync <= 5'h00;
        pin_last <= 5'h00;
    end else begin
        pin_meta <= {wake_request, high_mon_trip, high_sup_trip, low_mon_trip, low_sup_trip};
        pin_sync <= pin_meta;
        pin_last <= pin_sync;
    end
end

wire [4:0] pin_rise = pin_sync & ~pin_last;
wire wake_level = pin_sync[4];

// ----------------------------------------
// derived configuration
// ----------------------------------------
wire [6:0] lc = low_side_control_reg;
wire [6:0] hc = high_side_control_reg;
wire low_slow = (lc[`F_SUP_ENABLE] & ~lc[`F_SUP_FULL])
    | (lc[`F_MON_ENABLE] & ~lc[`F_MON_FULL]); // R4 R15
wire low_fast_risk = ~lc[`F_SUP_ENABLE] | lc[`F_SUP_FULL]
    | ~lc[`F_MON_ENABLE] | lc[`F_MON_FULL];
wire high_risk = (hc[`F_SUP_ENABLE] & ~hc[`F_SUP_FULL]
    & (~hc[`F_SUP_KEEP] | hc[`F_AUTO]))
    | (hc[`F_MON_ENABLE] & ~hc[`F_MON_FULL] & hc[`F_AUTO]);
wire affected = low_fast_risk & high_risk;
wire settle_clear = ~low_settle_flag & ~high_settle_flag;
wire deep_now = power_level >= `LEVEL_DEEP_MIN;
wire deep_next = next_level >= `LEVEL_DEEP_MIN;
wire wake_seen = wake_level | wake_latch;

// ----------------------------------------
// sleep sequencer
// ----------------------------------------
always @* begin
    next_state = state;
    next_level = power_level;
    wake_start = 1'b0;
    entry_take = 1'b0;
    case (state)
        ST_ACTIVE: begin
            if (entry_pending && (entry_level < `LEVEL_DEEP_MIN || settle_clear)) begin // R7
                next_state = ST_SLEEP;
                next_level = entry_level;
                entry_take = 1'b1;
            end
        end
        ST_SLEEP: begin
            if (wake_seen) begin // R8
                next_state = ST_WAKE;
                next_level = `LEVEL_ACTIVE;
                wake_start = 1'b1;
            end
        end
        ST_WAKE: begin
            if (!wake_busy) begin
                next_state = ST_ACTIVE;
            end
        end
        default: begin
            next_state = ST_ACTIVE;
            next_level = `LEVEL_ACTIVE;
        end
    endcase
end

// light sleep resumes at once; deep sleep waits the slow or fast count
wire [15:0] wake_load = !deep_now ? ONE_LOAD : (low_slow ? SLOW_LOAD : FAST_LOAD); // R4 R5

always @(posedge clock) begin
    if (!reset_n) begin // R9
        state <= ST_ACTIVE;
        power_level <= `LEVEL_ACTIVE;
        wake_latch <= 1'b0;
        cpu_hold <= 1'b0;
        low_sup_state <= `UNIT_OFF;
        low_mon_state <= `UNIT_OFF;
        high_sup_state <= `UNIT_OFF;
        high_mon_state <= `UNIT_OFF;
    end else begin
        state <= next_state;
        power_level <= next_level;
        cpu_hold <= (next_state != ST_ACTIVE);
        // a wake pulse during the entry cycle is held, not dropped
        if (wake_start) begin
            wake_latch <= 1'b0;
        end else if (wake_level && (entry_pending || state == ST_SLEEP)) begin // R8
            wake_latch <= 1'b1;
        end
        // unit states move on the same edge as the power level
        low_sup_state <= sup_map(lc[`F_SUP_ENABLE], lc[`F_SUP_KEEP], lc[`F_SUP_FULL],
            lc[`F_AUTO], deep_next); // R1 R2 R17
        low_mon_state <= mon_map(lc[`F_MON_ENABLE], lc[`F_MON_FULL], lc[`F_AUTO],
            deep_next, 1'b0); // R2 R3 R17
        high_sup_state <= sup_map(hc[`F_SUP_ENABLE], hc[`F_SUP_KEEP], hc[`F_SUP_FULL],
            hc[`F_AUTO], deep_next); // R6 R17
        high_mon_state <= mon_map(hc[`F_MON_ENABLE], hc[`F_MON_FULL], hc[`F_AUTO],
            deep_next, 1'b1); // R6 R13
    end
end

// ----------------------------------------
// timers
// ----------------------------------------
wire wr_fire = aw_held && w_held && !s_axi_bvalid;
wire wr_low = wr_fire && aw_addr_q == `ADDR_LOW_CTRL && wstrb_q[0];
wire wr_high = wr_fire && aw_addr_q == `ADDR_HIGH_CTRL && wstrb_q[0];
wire [15:0] low_load = wdata_q[`F_SUP_FULL] ? FAST_LOAD : SLOW_LOAD;
wire [15:0] high_load = wdata_q[`F_SUP_FULL] ? FAST_LOAD : SLOW_LOAD;

interval_timer #(.WIDTH(16)) low_settle (
    .clock(clock),
    .reset_n(reset_n),
    .start(wr_low), // R16
    .load(low_load),
    .busy(low_settle_flag)
);

interval_timer #(.WIDTH(16)) high_settle (
    .clock(clock),
    .reset_n(reset_n),
    .start(wr_high), // R16
    .load(high_load),
    .busy(high_settle_flag)
);

interval_timer #(.WIDTH(16)) wake_timer (
    .clock(clock),
    .reset_n(reset_n),
    .start(wake_start), // R5
    .load(wake_load),
    .busy(wake_busy)
);

// ----------------------------------------
// events, reset request and interrupt
// ----------------------------------------
wire low_sup_hit = pin_rise[0] && low_sup_state != `UNIT_OFF;
wire low_mon_hit = pin_rise[1] && low_mon_state != `UNIT_OFF;
wire high_sup_hit = pin_rise[2] && high_sup_state != `UNIT_OFF;
wire high_mon_hit = pin_rise[3] && high_mon_state != `UNIT_OFF; // R13
wire low_to_reset = lc[`F_RESET_SEL]; // R14
wire ovp_reset = hc[`F_RESET_SEL]; // R12
wire [4:0] event_set = {
    state == ST_WAKE && !wake_busy,
    high_mon_hit && !ovp_reset,
    high_sup_hit,
    low_mon_hit && !low_to_reset,
    low_sup_hit && !low_to_reset
};
wire flags_wr = wr_fire && aw_addr_q == `ADDR_FLAGS && wstrb_q[0];
wire [4:0] event_clear = flags_wr ? wdata_q[`F_WAKE_EVT:`F_LOW_SUP_EVT] : 5'h00;
wire [4:0] next_flags = event_set | (event_flags & ~event_clear);

always @(posedge clock) begin
    if (!reset_n) begin
        event_flags <= 5'h00;
        power_on_reset <= 1'b0;
        irq <= 1'b0;
    end else begin
        // a new event wins over a clear in the same cycle
        event_flags <= next_flags;
        power_on_reset <= ((low_sup_hit || low_mon_hit) && low_to_reset)
            || (high_mon_hit && ovp_reset); // R12 R14
        irq <= |(next_flags & event_mask);
    end
end

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge clock) begin
    if (!reset_n) begin
        low_side_control_reg <= `CTRL_RESET;
        high_side_control_reg <= `CTRL_RESET;
        event_mask <= `MASK_RESET;
        entry_pending <= 1'b0;
        entry_level <= `LEVEL_ACTIVE;
    end else begin
        if (entry_take) begin
            entry_pending <= 1'b0;
        end
        if (wr_low) begin
            low_side_control_reg <= wdata_q[`CTRL_WIDTH-1:0];
        end
        if (wr_high) begin
            high_side_control_reg <= wdata_q[`CTRL_WIDTH-1:0];
        end
        if (wr_fire && aw_addr_q == `ADDR_MASK && wstrb_q[0]) begin
            event_mask <= wdata_q[`F_WAKE_EVT:`F_LOW_SUP_EVT];
        end
        if (wr_fire && aw_addr_q == `ADDR_SLEEP && wstrb_q[0]
            && wdata_q[`F_SLEEP_GO] && state == ST_ACTIVE && !entry_take) begin
            entry_pending <= 1'b1;
            entry_level <= (wdata_q[2:0] > `LEVEL_MAX) ? `LEVEL_MAX : wdata_q[2:0];
        end
    end
end

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
wire wr_mapped = aw_addr_q == `ADDR_LOW_CTRL || aw_addr_q == `ADDR_HIGH_CTRL
    || aw_addr_q == `ADDR_FLAGS || aw_addr_q == `ADDR_MASK
    || aw_addr_q == `ADDR_SLEEP || aw_addr_q == `ADDR_STATE;

always @(posedge clock) begin
    if (!reset_n) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr_q <= 8'h00;
        wdata_q <= 32'h00000000;
        wstrb_q <= 4'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
wire [13:0] state_word = {affected, ~low_slow, state == ST_WAKE, high_mon_state,
    high_sup_state, low_mon_state, low_sup_state, power_level};

always @(posedge clock) begin
    if (!reset_n) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h0;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (rd_addr == `ADDR_LOW_CTRL) begin
                s_axi_rdata <= {25'h0, low_side_control_reg};
            end else if (rd_addr == `ADDR_HIGH_CTRL) begin
                s_axi_rdata <= {25'h0, high_side_control_reg};
            end else if (rd_addr == `ADDR_FLAGS) begin
                s_axi_rdata <= {25'h0, event_flags, high_settle_flag, low_settle_flag}; // R7
            end else if (rd_addr == `ADDR_MASK) begin
                s_axi_rdata <= {25'h0, event_mask, 2'b00};
            end else if (rd_addr == `ADDR_SLEEP) begin
                s_axi_rdata <= {28'h0, entry_pending, entry_level};
            end else if (rd_addr == `ADDR_STATE) begin
                s_axi_rdata <= {18'h0, state_word};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= 2'h2;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

// *** design/supervisor_regs.vh ***
// register map, field positions, reset values and timing figures
// assumes inclusion by the supervisor sleep control files only
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_LOW_CTRL 8'h00
`define ADDR_HIGH_CTRL 8'h04
`define ADDR_FLAGS 8'h08
`define ADDR_MASK 8'h0C
`define ADDR_SLEEP 8'h10
`define ADDR_STATE 8'h14

// ----------------------------------------
// side control fields (both sides)
// ----------------------------------------
`define F_SUP_ENABLE 0
`define F_SUP_KEEP 1
`define F_SUP_FULL 2
`define F_AUTO 3
`define F_MON_ENABLE 4
`define F_MON_FULL 5
`define F_RESET_SEL 6
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h00

// ----------------------------------------
// flag fields
// ----------------------------------------
`define F_LOW_SETTLE 0
`define F_HIGH_SETTLE 1
`define F_LOW_SUP_EVT 2
`define F_LOW_MON_EVT 3
`define F_HIGH_SUP_EVT 4
`define F_HIGH_MON_EVT 5
`define F_WAKE_EVT 6
`define FLAG_WIDTH 7
`define MASK_RESET 5'h00

// ----------------------------------------
// sleep request fields and unit states
// ----------------------------------------
`define F_SLEEP_GO 3
`define LEVEL_ACTIVE 3'h0
`define LEVEL_DEEP_MIN 3'h2
`define LEVEL_MAX 3'h4
`define UNIT_OFF 2'h0
`define UNIT_NORMAL 2'h1
`define UNIT_FULL 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_MHZ 200
`define T_SLOW_US 150
`define T_FAST_US 2

`endif

// *** design/interval_timer.v ***
// one-shot down counter, busy for exactly load cycles after start
// assumes load is at least one and start is a one-cycle pulse
`timescale 1ns/10ps
module interval_timer #(
    parameter WIDTH = 16
) (
    input wire clock,
    input wire reset_n,
    input wire start,
    input wire [WIDTH-1:0] load,
    output reg busy
);

reg [WIDTH-1:0] count;

// ----------------------------------------
// counter
// ----------------------------------------
always @(posedge clock) begin
    if (!reset_n) begin
        count <= {WIDTH{1'b0}};
        busy <= 1'b0;
    end else if (start) begin
        count <= load - {{(WIDTH-1){1'b0}}, 1'b1};
        busy <= 1'b1;
    end else if (busy) begin
        if (count == {WIDTH{1'b0}}) begin
            busy <= 1'b0;
        end else begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

endmodule

// *** tb/supply_supervisor_sleep_control_monitor.sv ***
// port checker for the supply supervisor sleep control block
// assumes bind onto the design top, one clock, sync active-low reset
`timescale 1ns/10ps
module supply_supervisor_sleep_control_monitor (
    input wire clock,
    input wire reset_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire low_sup_trip,
    input wire low_mon_trip,
    input wire high_sup_trip,
    input wire high_mon_trip,
    input wire [1:0] low_sup_state,
    input wire [1:0] low_mon_state,
    input wire [1:0] high_sup_state,
    input wire [1:0] high_mon_state,
    input wire cpu_hold,
    input wire power_on_reset
);
    // ----------------------------------------
    // cycles since a trip pin was last high
    // ----------------------------------------
    reg [3:0] since_trip;
    always @(posedge clock) begin
        if (!reset_n)
            since_trip <= 4'hF;
        else if (low_sup_trip | low_mon_trip | high_sup_trip | high_mon_trip)
            since_trip <= 4'h0;
        else if (since_trip != 4'hF)
            since_trip <= since_trip + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_B_CODE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready &&
        !s_axi_bresp[0]) else $error("write response state wrong");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_STATE_CODES: assert property (low_sup_state != 2'h3 && low_mon_state != 2'h3 &&
        high_sup_state != 2'h3 && high_mon_state != 2'h3) else $error("unit state code");
    AST_RESET_PULSE: assert property (power_on_reset |=> !power_on_reset)
        else $error("reset pulse too long");
    AST_RESET_CAUSE: assert property (power_on_reset |-> since_trip < 4'h8)
        else $error("reset pulse without trip");
    AST_WAKE_SETTLED: assert property ($fell(cpu_hold) |-> $stable(low_sup_state) &&
        $stable(high_sup_state)) else $error("units changed at hold release");
    cover property ($fell(cpu_hold));
    cover property (power_on_reset);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind supply_supervisor_sleep_control supply_supervisor_sleep_control_monitor
    supply_supervisor_sleep_control_monitor_i (.*);

// *** tb/supply_supervisor_sleep_control_bench.sv ***
// self-checking bench for the supply supervisor sleep control block
// assumes design and bound monitor compiled ahead; shortened slow count
`timescale 1ns/10ps
`include "supervisor_regs.vh"
module supply_supervisor_sleep_control_bench;
    localparam SLOW = 20;
    localparam FAST = 400;
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'h0, trip = 4'h0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wake_request = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, low_sup_state, low_mon_state;
    wire [1:0] high_sup_state, high_mon_state;
    wire [31:0] s_axi_rdata;
    wire cpu_hold, power_on_reset, irq;
    integer err_total = 0, samples_checked = 0, cycles = 0, por_n = 0;
    integer seed = 32'h203fdcf0;
    integer i, n, t;
    reg [31:0] rd;
    reg [1:0] resp;
    reg [6:0] lc, hc;
    reg [2:0] lvl;
    reg deep;
    supply_supervisor_sleep_control #(.SLOW_CYCLES(SLOW)) supply_supervisor_sleep_control_i (
        .*, .low_sup_trip(trip[0]), .low_mon_trip(trip[1]), .high_sup_trip(trip[2]),
        .high_mon_trip(trip[3]));
    always #2.5 clock = ~clock;
    // negedge sampling avoids racing the design's own flops
    always @(negedge clock) if (power_on_reset === 1'b1) por_n = por_n + 1;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            err_total = err_total + 1;
            results;
        end
    end
    // ----------------------------------------
    // expectation functions
    // ----------------------------------------
    function [1:0] sup_map(input en, keep, full, auto, dp);
        sup_map = !en ? 2'h0 : !dp ? {full, !full} :
            !auto ? (keep ? {full, !full} : 2'h0) : {1'b0, keep & full};
    endfunction
    function [1:0] mon_map(input en, full, auto, dp, high);
        mon_map = !en ? 2'h0 : (!dp || !auto) ? {full, !full} : {1'b0, full & !high};
    endfunction
    function [7:0] units(input [6:0] l, h, input dp);
        units = {mon_map(h[4], h[5], h[3], dp, 1'b1), sup_map(h[0], h[1], h[2], h[3], dp),
            mon_map(l[4], l[5], l[3], dp, 1'b0), sup_map(l[0], l[1], l[2], l[3], dp)};
    endfunction
    function fast(input [6:0] l);
        fast = !((l[0] & !l[2]) | (l[4] & !l[5]));
    endfunction
    function aff(input [6:0] l, h);
        aff = (!l[0] | l[2] | !l[4] | l[5]) &
            ((h[0] & !h[2] & (!h[1] | h[3])) | (h[4] & !h[5] & h[3]));
    endfunction
    // ----------------------------------------
    // bus, pin and compare tasks
    // ----------------------------------------
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clock);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hF;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge clock);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task rdw(input [7:0] a);
        begin
            @(posedge clock);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge clock);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task pulse(input integer b);
        begin
            @(posedge clock);
            trip[b] <= 1'b1;
            repeat (6) @(posedge clock);
            trip[b] <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask
    task wait_hold(input v);
        begin
            n = 0;
            do begin
                @(posedge clock);
                n = n + 1;
            end while (cpu_hold !== v && n < 2000);
            chk("hold", cpu_hold, v);
        end
    endtask
    task results;
        begin
            if (err_total == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("ready", {s_axi_awready, s_axi_wready, s_axi_arready, cpu_hold, irq}, 5'h1C);
        rdw(`ADDR_STATE);
        chk("state", rd, 32'h00001000);
        rdw(8'h18);
        chk("unmapped", {rd[29:0], resp}, 32'h2);
        wr(8'h18, 32'hFF);
        chk("bresp", resp, 32'h2);
        wr(`ADDR_LOW_CTRL, 32'h01);
        rdw(`ADDR_FLAGS);
        chk("settle", rd, 32'h1);
        repeat (25) @(posedge clock);
        wr(`ADDR_MASK, 32'h04);
        pulse(0);
        chk("irq", irq, 32'h1);
        rdw(`ADDR_FLAGS);
        chk("flags", rd, 32'h04);
        wr(`ADDR_FLAGS, 32'h04);
        rdw(`ADDR_FLAGS);
        chk("cleared", {rd[30:0], irq}, 32'h0);
        wr(`ADDR_LOW_CTRL, 32'h41);
        n = por_n;
        pulse(0);
        chk("low por", por_n - n, 32'h1);
        wr(`ADDR_HIGH_CTRL, 32'h50);
        n = por_n;
        pulse(3);
        chk("high por", por_n - n, 32'h1);
        wr(`ADDR_HIGH_CTRL, 32'h10);
        wr(`ADDR_MASK, 32'h00);
        pulse(3);
        rdw(`ADDR_FLAGS);
        chk("masked", {rd[31:2], irq}, 32'h10);
        wr(`ADDR_FLAGS, 32'h7C);
        for (i = 0; i < 12; i = i + 1) begin
            lc = (i == 0) ? 7'h0F : (i == 1) ? 7'h35 : $random(seed);
            hc = (i == 0) ? 7'h13 : $random(seed);
            lc[6] = 1'b0; // reset select kept off, sleep is the subject here
            hc[6] = 1'b0;
            lvl = (i == 0) ? 3'h7 : i[2:0] % 3'h5;
            deep = lvl >= 3'h2;
            wr(`ADDR_LOW_CTRL, {25'h0, lc});
            wr(`ADDR_HIGH_CTRL, {25'h0, hc});
            rdw(`ADDR_STATE);
            chk("state", rd, {18'h0, aff(lc, hc), fast(lc), 1'b0, units(lc, hc, 1'b0), 3'h0});
            if (aff(lc, hc) && deep) repeat (SLOW) @(posedge clock);
            wr(`ADDR_SLEEP, {28'h0, 1'b1, lvl});
            if (i % 4 == 3) wake_request <= 1'b1;
            wait_hold(1'b1);
            if (deep && (lc[2] | hc[2])) chk("deep entry", n >= 300, 32'h1);
            if (i % 4 != 3) begin
                repeat (2) @(posedge clock);
                chk("asleep", {high_mon_state, high_sup_state, low_mon_state, low_sup_state},
                    units(lc, hc, deep));
                rdw(`ADDR_STATE);
                chk("level", rd[2:0], (lvl > 3'h4) ? 3'h4 : lvl);
                wake_request <= 1'b1;
            end
            t = deep ? (fast(lc) ? FAST : SLOW) : 1;
            wait_hold(1'b0);
            chk("wake time", n >= t && n <= t + 8, 32'h1);
            wake_request <= 1'b0;
            chk("awake", {high_mon_state, high_sup_state, low_mon_state, low_sup_state},
                units(lc, hc, 1'b0));
            rdw(`ADDR_FLAGS);
            chk("wake flag", rd[6], 32'h1);
            wr(`ADDR_FLAGS, 32'h40);
        end
        wr(`ADDR_LOW_CTRL, 32'h00);
        wr(`ADDR_SLEEP, 32'h0C);
        wait_hold(1'b1);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        rdw(`ADDR_STATE);
        chk("reset wake", {rd[30:0], cpu_hold}, 32'h00002000);
        results;
    end
endmodule
